// [src/rspg_pkg.sv]
package rspg_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [3:0] RSPG_ADDR_STATUS = 4'h0;
	localparam logic [3:0] RSPG_ADDR_CTRL   = 4'h1;
	localparam logic [3:0] RSPG_ADDR_POWER  = 4'h2;
	localparam logic [3:0] RSPG_ADDR_SCAN   = 4'h3;

	// Reset status flag positions
	localparam int RSPG_FLAG_POR  = 0;
	localparam int RSPG_FLAG_EXT  = 1;
	localparam int RSPG_FLAG_BOD  = 2;
	localparam int RSPG_FLAG_WDT  = 3;
	localparam int RSPG_FLAG_SCAN = 4;
	localparam int RSPG_NUM_SRC   = 5;

	// Control register bit positions
	localparam int RSPG_CTRL_SCAN_DIS = 7;
	localparam int RSPG_CTRL_ADC_EN   = 0;
	localparam int RSPG_CTRL_ACMP_EN  = 1;
	localparam int RSPG_CTRL_ACMP_BG  = 2;
	localparam int RSPG_CTRL_WDT_EN   = 3;

	localparam logic [7:0] RSPG_CTRL_RESET   = 8'h00;
	localparam logic [4:0] RSPG_FLAGS_RESET  = 5'h00;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int RSPG_CLK_MHZ        = 50;
	localparam int RSPG_EXT_MIN_NS     = 1500;
	// Least time rounds up
	localparam int RSPG_EXT_MIN_CYC    =
		(RSPG_EXT_MIN_NS * RSPG_CLK_MHZ + 999) / 1000;
	localparam int RSPG_TOUT_W         = 24;

	// ---------------------------------------------------------------
	// Sleep modes (encoding supplied from outside)
	// ---------------------------------------------------------------
	typedef enum logic [5:0] {
		RSPG_SLP_IDLE = 6'h01,
		RSPG_SLP_ADCN = 6'h02,
		RSPG_SLP_PDN  = 6'h04,
		RSPG_SLP_PSV  = 6'h08,
		RSPG_SLP_SBY  = 6'h10,
		RSPG_SLP_XSBY = 6'h20
	} rspg_slp_t;

	typedef enum logic [2:0] {
		RSPG_ST_HOLD = 3'b001,
		RSPG_ST_WAIT = 3'b010,
		RSPG_ST_RUN  = 3'b100
	} rspg_st_t;

	// Power gating outputs travel together
	typedef struct packed {
		logic adc_pwr;
		logic adc_extended;
		logic acmp_pwr;
		logic vref_pwr;
		logic bod_pwr;
		logic wdt_pwr;
		logic in_buf_en;
		logic wake_in_en;
		logic main_clk_keep;
		logic scan_en;
	} rspg_pwr_t;

	// Bus request from software
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} rspg_bus_t;

	typedef struct packed {
		rspg_st_t                 st;
		logic [RSPG_TOUT_W-1:0]   cnt;
		logic [15:0]              ext_cnt;
		logic                     ext_act;
		logic [1:0]               req_sync;
		logic [4:0]               flags;
		logic [7:0]               ctrl;
		logic                     adc_was_off;
		logic                     adc_ext_pend;
		logic [7:0]               rdata;
		logic                     int_rst;
		logic                     port_init;
		rspg_pwr_t                pwr;
	} rspg_state_t;

	function automatic logic rspg_deep_sleep(input logic sleeping,
		input rspg_slp_t mode);
		return sleeping && (mode != RSPG_SLP_IDLE) &&
			(mode != RSPG_SLP_ADCN);
	endfunction

endpackage

// [src/rspg_top.sv]
// The register offsets and strobed register access were decided locally.
`timescale 1ns/10ps

// What this block does
// - An enabled converter stays powered in every sleep mode.
// - First conversion after converter re-enable is flagged as extended.
// - Comparator is switched off in sleep modes deeper than idle/noise.
// - Comparator on internal reference keeps that reference powered always.
// - Reference is powered when detector, comparator or converter need it.
// - Fuse-enabled brown-out detector stays active in all sleep modes.
// - Enabled watchdog keeps running in all sleep modes.
// - Input buffers off when both I/O and converter clocks stop.
// - Wake-up pins keep input logic enabled during such sleep.
// - Debug fuse keeps main clock running in power-down/power-save.
// - Scan port off by software disable bit or unprogrammed fuse.
// - Scan data out undriven while enabled and not shifting.
// - Reset loads I/O registers; fetch starts at reset vector after.
// - Ports go to initial state at once on any reset source.
// - After sources release, delay counter stretches internal reset.
// - Five reset sources; power-on asserts below its threshold.
// - Low reset pin beyond minimum pulse length causes external reset.
// - Watchdog expiry with watchdog enabled causes watchdog reset.
// - Brown-out reset only while detector enabled and supply low.
// - Scan reset register at one holds the core in reset.
// - Each source sets its flag; software clears by writing zero.
// - Watchdog reset lasts until expiry falls or held reset clears the enable bit; time-out starts after it.
module rspg_top
	import rspg_pkg::*;
#(
	parameter int TOUT_CYCLES = 65536,
	parameter int EXT_MIN_CYC = RSPG_EXT_MIN_CYC
) (
	input  wire logic       CORE_CLK_I,
	input  wire logic       RST_N_I,
	input  wire logic       POWER_ON_LOW_I,
	input  wire logic       RESET_PIN_N_I,
	input  wire logic       WDT_EXPIRE_I,
	input  wire logic       BROWNOUT_LOW_I,
	input  wire logic       SCAN_RESET_REG_I,
	input  wire logic       BROWNOUT_DETECTOR_FUSE_ENABLE_I,
	input  wire logic       ONCHIP_DEBUG_FUSE_ENABLE_I,
	input  wire logic       SCAN_PORT_FUSE_ENABLE_I,
	input  wire logic [RSPG_TOUT_W-1:0] CLOCK_SELECT_TOUT_I,
	input  wire logic       SLEEP_I,
	input  wire logic [5:0] SLEEP_MODE_I,
	input  wire logic       SCAN_SHIFT_I,
	input  wire logic       SCAN_TDO_I,
	input  wire logic [3:0] ADDR_I,
	input  wire logic [7:0] WDATA_I,
	input  wire logic       WR_I,
	input  wire logic       RD_I,
	output logic      [7:0] RDATA_O,
	output logic            INT_RESET_O,
	output logic            PORT_INIT_O,
	output logic            FETCH_VECTOR_O,
	output logic            ADC_PWR_O,
	output logic            ADC_EXTENDED_O,
	output logic            ACMP_PWR_O,
	output logic            VREF_PWR_O,
	output logic            BOD_PWR_O,
	output logic            WDT_PWR_O,
	output logic            IN_BUF_EN_O,
	output logic            WAKE_IN_EN_O,
	output logic            MAIN_CLK_KEEP_O,
	output logic            SCAN_EN_O,
	output logic            TDO_O,
	output logic            TDO_OE_N_O
);

	rspg_state_t s_q;
	rspg_state_t s_d;
	rspg_bus_t   bus;
	rspg_slp_t   mode;
	logic        deep;
	logic        clk_stop_all;
	logic        ext_low;
	logic        bod_rst;
	logic        wdt_pulse;
	logic [4:0]  src;
	logic        any_src;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// One decode point, so every register sees the same strobe rule
	function automatic logic wr_hit(
		input rspg_bus_t  b,
		input logic [3:0] a
	);
		return b.wr && (b.addr == a);
	endfunction

	// Gating for the next cycle; outputs land one cycle after sleep or fuse inputs, two after a register write
	function automatic rspg_pwr_t pwr_next(
		input logic [7:0] ctrl,
		input logic       ext_pend,
		input logic       sleeping,
		input rspg_slp_t  slp_mode,
		input logic       deep_slp,
		input logic       stop_all,
		input logic       bod_fuse,
		input logic       dbg_fuse,
		input logic       scan_fuse
	);
		rspg_pwr_t p;
		logic      adc_on;
		logic      acmp_on;
		logic      acmp_ref;
		logic      osc_mode;
		p        = '0;
		adc_on   = ctrl[RSPG_CTRL_ADC_EN];
		acmp_on  = ctrl[RSPG_CTRL_ACMP_EN];
		acmp_ref = acmp_on & ctrl[RSPG_CTRL_ACMP_BG];
		// Modes in which the main oscillator runs anyway
		osc_mode = (slp_mode == RSPG_SLP_IDLE) |
			(slp_mode == RSPG_SLP_ADCN) |
			(slp_mode == RSPG_SLP_SBY) |
			(slp_mode == RSPG_SLP_XSBY);

		// Never gated by sleep; software must switch it off itself
		p.adc_pwr       = adc_on;
		p.adc_extended  = ext_pend;
		// Comparator drops in deep sleep even when on the reference;
		// only the reference stays up on its behalf
		p.acmp_pwr      = acmp_on & ~deep_slp;
		p.vref_pwr      = bod_fuse | acmp_ref | adc_on;
		p.bod_pwr       = bod_fuse;
		p.wdt_pwr       = ctrl[RSPG_CTRL_WDT_EN];
		p.in_buf_en     = ~stop_all;
		// Which pins wake the core is chosen outside, so this stays open
		p.wake_in_en    = 1'b1;
		// Debug keeps the oscillator alive at the price of sleep current
		p.main_clk_keep = ~sleeping | osc_mode | dbg_fuse;
		p.scan_en       = scan_fuse & ~ctrl[RSPG_CTRL_SCAN_DIS];
		return p;
	endfunction

	// Read view; unmapped offsets read as zero
	function automatic logic [7:0] reg_view(
		input rspg_state_t s,
		input logic [3:0]  a
	);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			RSPG_ADDR_STATUS: v = {3'h0, s.flags};
			RSPG_ADDR_CTRL:   v = s.ctrl;
			RSPG_ADDR_POWER:  v = {s.pwr.scan_en, s.pwr.in_buf_en,
				s.pwr.wdt_pwr, s.pwr.bod_pwr, s.pwr.vref_pwr,
				s.pwr.acmp_pwr, s.pwr.adc_extended, s.pwr.adc_pwr};
			RSPG_ADDR_SCAN:   v = {5'h00, s.st};
			default:          v = 8'h00;
		endcase
		return v;
	endfunction

	// Image loaded by the core reset; the sync starts asserted so that
	// no release is seen before the first real sample of the sources
	localparam rspg_state_t RSPG_STATE_RESET = '{
		st:           RSPG_ST_HOLD,
		cnt:          '0,
		ext_cnt:      '0,
		ext_act:      1'b0,
		req_sync:     2'b11,
		flags:        RSPG_FLAGS_RESET,
		ctrl:         RSPG_CTRL_RESET,
		adc_was_off:  1'b1,
		adc_ext_pend: 1'b0,
		rdata:        8'h00,
		int_rst:      1'b1,
		port_init:    1'b1,
		pwr:          '0
	};

	assign bus  = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
	assign mode = rspg_slp_t'(SLEEP_MODE_I);

	// ---------------------------------------------------------------
	// Reset sources
	// ---------------------------------------------------------------
	assign ext_low   = ~RESET_PIN_N_I;
	assign bod_rst   = BROWNOUT_LOW_I & BROWNOUT_DETECTOR_FUSE_ENABLE_I;
	// Expiry only counts while the watchdog is enabled
	assign wdt_pulse = WDT_EXPIRE_I & s_q.ctrl[RSPG_CTRL_WDT_EN];

	always_comb begin
		src = '0;
		src[RSPG_FLAG_POR]  = POWER_ON_LOW_I;
		src[RSPG_FLAG_EXT]  = s_q.ext_act;
		src[RSPG_FLAG_BOD]  = bod_rst;
		src[RSPG_FLAG_WDT]  = wdt_pulse;
		src[RSPG_FLAG_SCAN] = SCAN_RESET_REG_I;
	end

	assign any_src = |src;

	// ---------------------------------------------------------------
	// Sleep classification
	// ---------------------------------------------------------------
	assign deep = rspg_deep_sleep(SLEEP_I, mode);
	// Every mode but idle and noise reduction stops both clocks
	assign clk_stop_all = deep;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		s_d = s_q;

		// -----------------------------------------------------------
		// Pin filter
		// -----------------------------------------------------------
		// Only a low held past the minimum counts; short glitches never
		// reach the sequencer
		if (ext_low) begin
			if (s_q.ext_cnt >= 16'(EXT_MIN_CYC))
				s_d.ext_act = 1'b1;
			else
				s_d.ext_cnt = s_q.ext_cnt + 16'h0001;
		end else begin
			s_d.ext_cnt = '0;
			s_d.ext_act = 1'b0;
		end

		// -----------------------------------------------------------
		// Reset sequencing
		// -----------------------------------------------------------
		s_d.req_sync = {s_q.req_sync[0], any_src};

		unique case (s_q.st)
			RSPG_ST_HOLD: begin
				s_d.int_rst = 1'b1;
				if (!s_q.req_sync[1]) begin
					s_d.st  = RSPG_ST_WAIT;
					s_d.cnt = CLOCK_SELECT_TOUT_I;
				end
			end
			RSPG_ST_WAIT: begin
				if (s_q.req_sync[1])
					s_d.st = RSPG_ST_HOLD;
				else if (s_q.cnt == '0) begin
					s_d.st      = RSPG_ST_RUN;
					s_d.int_rst = 1'b0;
				end else
					s_d.cnt = s_q.cnt - 24'h000001;
			end
			RSPG_ST_RUN: begin
				if (s_q.req_sync[1]) begin
					s_d.st      = RSPG_ST_HOLD;
					s_d.int_rst = 1'b1;
				end
			end
			default: begin
				s_d.st      = RSPG_ST_HOLD;
				s_d.int_rst = 1'b1;
			end
		endcase

		// -----------------------------------------------------------
		// Status and control
		// -----------------------------------------------------------
		// Software write: zero clears a flag; a set in the same cycle wins
		if (wr_hit(bus, RSPG_ADDR_STATUS))
			s_d.flags = s_q.flags & bus.wdata[4:0];
		if (wr_hit(bus, RSPG_ADDR_CTRL))
			s_d.ctrl = bus.wdata;
		// Power-on clears the other flags, keeps its own set
		if (POWER_ON_LOW_I)
			s_d.flags = 5'(1 << RSPG_FLAG_POR);
		else
			s_d.flags = s_d.flags | src;

		// Converter re-enable arms an extended first conversion
		s_d.adc_was_off = ~s_d.ctrl[RSPG_CTRL_ADC_EN];
		if (s_q.adc_was_off && s_d.ctrl[RSPG_CTRL_ADC_EN])
			s_d.adc_ext_pend = 1'b1;
		else if (!s_d.ctrl[RSPG_CTRL_ADC_EN])
			s_d.adc_ext_pend = 1'b0;
		if (wr_hit(bus, RSPG_ADDR_SCAN) && bus.wdata[0])
			s_d.adc_ext_pend = 1'b0;

		// -----------------------------------------------------------
		// Power gating and read port
		// -----------------------------------------------------------
		s_d.pwr   = pwr_next(s_q.ctrl, s_q.adc_ext_pend, SLEEP_I, mode,
			deep, clk_stop_all, BROWNOUT_DETECTOR_FUSE_ENABLE_I,
			ONCHIP_DEBUG_FUSE_ENABLE_I, SCAN_PORT_FUSE_ENABLE_I);
		// Zero outside the answer cycle keeps the bus quiet
		s_d.rdata = bus.rd ? reg_view(s_q, bus.addr) : 8'h00;

		// While reset is held, the controls return to their initial values
		if (s_q.int_rst) begin
			s_d.ctrl = RSPG_CTRL_RESET;
		end
		s_d.port_init = s_d.int_rst;
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			s_q <= RSPG_STATE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign RDATA_O         = s_q.rdata;
	assign INT_RESET_O     = s_q.int_rst;
	// Combinational path so ports reset without waiting for any edge
	assign PORT_INIT_O     = any_src | s_q.port_init;
	assign FETCH_VECTOR_O  = s_q.st == RSPG_ST_WAIT &&
		s_q.cnt == '0 && !s_q.req_sync[1];
	assign ADC_PWR_O       = s_q.pwr.adc_pwr;
	assign ADC_EXTENDED_O  = s_q.pwr.adc_extended;
	assign ACMP_PWR_O      = s_q.pwr.acmp_pwr;
	assign VREF_PWR_O      = s_q.pwr.vref_pwr;
	assign BOD_PWR_O       = s_q.pwr.bod_pwr;
	assign WDT_PWR_O       = s_q.pwr.wdt_pwr;
	assign IN_BUF_EN_O     = s_q.pwr.in_buf_en;
	assign WAKE_IN_EN_O    = s_q.pwr.wake_in_en;
	assign MAIN_CLK_KEEP_O = s_q.pwr.main_clk_keep;
	assign SCAN_EN_O       = s_q.pwr.scan_en;
	assign TDO_O           = SCAN_TDO_I;
	// Driven only while enabled and shifting
	assign TDO_OE_N_O      = ~(s_q.pwr.scan_en & SCAN_SHIFT_I);

endmodule

// [dv/rspg_top_assertions.sv]
`timescale 1ns/10ps
module rspg_top_assertions (
	input wire logic       CORE_CLK_I,
	input wire logic       RST_N_I,
	input wire logic       POWER_ON_LOW_I,
	input wire logic       SCAN_RESET_REG_I,
	input wire logic       ONCHIP_DEBUG_FUSE_ENABLE_I,
	input wire logic       SCAN_PORT_FUSE_ENABLE_I,
	input wire logic       SLEEP_I,
	input wire logic [5:0] SLEEP_MODE_I,
	input wire logic       SCAN_SHIFT_I,
	input wire logic       RD_I,
	input wire logic [7:0] RDATA_O,
	input wire logic       INT_RESET_O,
	input wire logic       PORT_INIT_O,
	input wire logic       FETCH_VECTOR_O,
	input wire logic       ACMP_PWR_O,
	input wire logic       IN_BUF_EN_O,
	input wire logic       MAIN_CLK_KEEP_O,
	input wire logic       SCAN_EN_O,
	input wire logic       TDO_OE_N_O
);
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_N_I);
	property p_port_init;
		POWER_ON_LOW_I || SCAN_RESET_REG_I |-> PORT_INIT_O;
	endproperty
	a_port_init: assert property (p_port_init)
		else $error("ports not forced to initial state");
	property p_por;
		POWER_ON_LOW_I |-> ##[1:3] INT_RESET_O;
	endproperty
	a_por: assert property (p_por)
		else $error("power-on source did not reset");
	property p_scan_rst;
		SCAN_RESET_REG_I [*4] |-> INT_RESET_O;
	endproperty
	a_scan_rst: assert property (p_scan_rst)
		else $error("scan reset register did not hold reset");
	property p_fetch;
		$fell(INT_RESET_O) |-> $past(FETCH_VECTOR_O);
	endproperty
	a_fetch: assert property (p_fetch)
		else $error("reset ended without vector fetch");
	property p_acmp;
		SLEEP_I && SLEEP_MODE_I[5:2] != 4'h0 |=> !ACMP_PWR_O;
	endproperty
	a_acmp: assert property (p_acmp)
		else $error("comparator powered in deep sleep");
	property p_inbuf;
		SLEEP_I && SLEEP_MODE_I[5:2] != 4'h0 |=> !IN_BUF_EN_O;
	endproperty
	a_inbuf: assert property (p_inbuf)
		else $error("input buffers on in deep sleep");
	property p_clk;
		ONCHIP_DEBUG_FUSE_ENABLE_I && SLEEP_I && !INT_RESET_O &&
			SLEEP_MODE_I[3:2] != 2'h0 |=> MAIN_CLK_KEEP_O;
	endproperty
	a_clk: assert property (p_clk)
		else $error("main clock dropped with debug fuse");
	property p_scan;
		!SCAN_PORT_FUSE_ENABLE_I |=> !SCAN_EN_O;
	endproperty
	a_scan: assert property (p_scan)
		else $error("scan port enabled without fuse");
	property p_tdo;
		!SCAN_SHIFT_I [*2] |-> TDO_OE_N_O;
	endproperty
	a_tdo: assert property (p_tdo)
		else $error("scan data out driven while not shifting");
	property p_rdata;
		!$past(RD_I) |-> RDATA_O == 8'h00;
	endproperty
	a_rdata: assert property (p_rdata)
		else $error("read data outside read answer cycle");
endmodule
bind rspg_top rspg_top_assertions u_chk (.CORE_CLK_I, .RST_N_I,
	.POWER_ON_LOW_I, .SCAN_RESET_REG_I, .ONCHIP_DEBUG_FUSE_ENABLE_I,
	.SCAN_PORT_FUSE_ENABLE_I, .SLEEP_I, .SLEEP_MODE_I, .SCAN_SHIFT_I,
	.RD_I, .RDATA_O, .INT_RESET_O, .PORT_INIT_O, .FETCH_VECTOR_O,
	.ACMP_PWR_O, .IN_BUF_EN_O, .MAIN_CLK_KEEP_O, .SCAN_EN_O, .TDO_OE_N_O);

// [dv/rspg_top_tb.sv]
`timescale 1ns/10ps
`define CHK(a, e) begin \
	n_compared++; \
	if ((a) !== (e)) begin \
		n_mismatch++; \
		$display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); \
	end \
end
module rspg_top_tb;
	import rspg_pkg::*;
	localparam int TOUT = 10;
	logic       clk, rst_n, bodf, dbgf, scnf, slp, shift, tdo, wr_s, rd_s;
	logic [4:0] src;
	logic [5:0] mode;
	logic [3:0] addr;
	logic [7:0] wdata, rdata;
	logic       irst, pinit, fetch, adc, adcx, acmp, vref, bod, wdt;
	logic       inbuf, wake, ckeep, scan_en, tdo_o, oe_n;
	int         n_mismatch = 0;
	int         n_compared = 0;
	int         cyc;
	logic       seen;
	rspg_top #(.TOUT_CYCLES(16), .EXT_MIN_CYC(3)) DUT (.CORE_CLK_I(clk),
		.RST_N_I(rst_n), .POWER_ON_LOW_I(src[0]), .RESET_PIN_N_I(~src[1]),
		.WDT_EXPIRE_I(src[3]), .BROWNOUT_LOW_I(src[2]),
		.SCAN_RESET_REG_I(src[4]), .BROWNOUT_DETECTOR_FUSE_ENABLE_I(bodf),
		.ONCHIP_DEBUG_FUSE_ENABLE_I(dbgf), .SCAN_PORT_FUSE_ENABLE_I(scnf),
		.CLOCK_SELECT_TOUT_I(24'(TOUT)), .SLEEP_I(slp), .SLEEP_MODE_I(mode),
		.SCAN_SHIFT_I(shift), .SCAN_TDO_I(tdo), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata),
		.INT_RESET_O(irst), .PORT_INIT_O(pinit), .FETCH_VECTOR_O(fetch),
		.ADC_PWR_O(adc), .ADC_EXTENDED_O(adcx), .ACMP_PWR_O(acmp),
		.VREF_PWR_O(vref), .BOD_PWR_O(bod), .WDT_PWR_O(wdt),
		.IN_BUF_EN_O(inbuf), .WAKE_IN_EN_O(wake), .MAIN_CLK_KEEP_O(ckeep),
		.SCAN_EN_O(scan_en), .TDO_O(tdo_o), .TDO_OE_N_O(oe_n));
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		tick(3);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask
	task automatic wait_rst(input logic v);
		cyc = 0;
		seen = 1'b0;
		while (irst !== v && cyc < 300) begin
			seen = seen | fetch;
			tick(1);
			cyc++;
		end
		`CHK(irst, v)
	endtask
	task automatic fire(input int f, input int n);
		@(posedge clk);
		src[f] <= 1'b1;
		#1;
		if (f != 1 && (f != 2 || bodf))
			`CHK(pinit, 1'b1)
		repeat (n) @(posedge clk);
		src[f] <= 1'b0;
	endtask
	// Level set and strobes idle at time zero; power-on held from start
	initial begin
		{bodf, shift, tdo, wr_s, rd_s, slp, rst_n, addr, wdata} = '0;
		{dbgf, scnf, src, mode} = {2'b11, 5'h01, 6'h01};
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		// Supply stays low past release so its flag is captured
		repeat (2) @(posedge clk);
		src[0] <= 1'b0;
		wait_rst(1'b0);
		`CHK(1'(cyc >= TOUT), 1'b1)
		`CHK(seen, 1'b1)
		rd(RSPG_ADDR_STATUS, 8'h01);
		wr(RSPG_ADDR_STATUS, 8'h00);
		rd(RSPG_ADDR_STATUS, 8'h00);
		for (int f = 1; f < RSPG_NUM_SRC; f++) begin
			@(posedge clk);
			bodf <= 1'(f == 2);
			if (f == 3)
				wr(RSPG_ADDR_CTRL, 8'h08);
			fire(f, (f == 3) ? 1 : 6);
			wait_rst(1'b1);
			wait_rst(1'b0);
			rd(RSPG_ADDR_STATUS, 8'(1 << f));
			wr(RSPG_ADDR_STATUS, 8'h00);
		end
		// Pin low too short, and brown-out with detector fuse blank
		fire(1, 1);
		fire(2, 6);
		tick(4);
		`CHK(irst, 1'b0)
		rd(RSPG_ADDR_STATUS, 8'h00);
		wr(RSPG_ADDR_CTRL, 8'h0F);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			mode <= 6'(1 << i);
			slp <= 1'b1;
			tick(3);
			`CHK(adc, 1'b1)
			`CHK(acmp, 1'(i < 2))
			`CHK(wdt, 1'b1)
			`CHK(inbuf, 1'(i < 2))
			`CHK(wake, 1'b1)
			if (i == 2 || i == 3)
				`CHK(ckeep, 1'b1)
		end
		wr(RSPG_ADDR_CTRL, 8'h06);
		`CHK(vref, 1'b1)
		wr(RSPG_ADDR_CTRL, 8'h00);
		`CHK(vref, 1'b0)
		@(posedge clk);
		bodf <= 1'b1;
		tick(3);
		`CHK(vref, 1'b1)
		`CHK(bod, 1'b1)
		@(posedge clk);
		{bodf, slp} <= 2'b00;
		wr(RSPG_ADDR_CTRL, 8'h01);
		`CHK(adcx, 1'b1)
		wr(RSPG_ADDR_SCAN, 8'h01);
		`CHK(adcx, 1'b0)
		wr(RSPG_ADDR_CTRL, 8'h80);
		`CHK(scan_en, 1'b0)
		wr(RSPG_ADDR_CTRL, 8'h00);
		`CHK(scan_en, 1'b1)
		@(posedge clk);
		{shift, tdo} <= 2'b11;
		tick(3);
		`CHK({oe_n, tdo_o}, 2'b01)
		@(posedge clk);
		{shift, scnf} <= 2'b00;
		tick(3);
		`CHK({oe_n, scan_en}, 2'b10)
		rd(4'hF, 8'h00);
		tally_and_finish();
	end
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Whole sequence needs about 250 cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		tally_and_finish();
	end
endmodule
